//--- scb_baud_counter.sv
`timescale 1ns/1ns
module scb_baud_counter #(
  parameter int WIDTH = 8
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic load, // reload from value
  input wire logic run, // count down enable
  input wire logic [WIDTH-1:0] reload_value, // reload source
  output logic expired // count reached zero
);
  logic [WIDTH-1:0] count;
  wire at_zero = (count == '0);
  // ----------------------------------------
  // Down counter
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      expired <= 1'b0;
    end else begin
      expired <= run && !load && at_zero;
      if (load) begin
        count <= reload_value;
      end else if (run && !at_zero) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : scb_baud_counter

//--- scb_bus_partner.sv
`timescale 1ns/1ns
// ----------------------------------------
// Other masters and slaves on the bus
// ----------------------------------------
module scb_bus_partner (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic scl_oe_dut, // design pulls clock low
  input wire logic hold_sda, // hold data low
  input wire logic hold_scl, // hold clock low
  input wire logic [3:0] stretch, // stretch length in cycles
  output logic sda_pull, // partner pulls data low
  output logic scl_pull // partner pulls clock low
);
  logic [3:0] stretch_left;
  // A slow slave keeps the clock low for a while after the design lets it go.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_left <= 4'h0;
    end else if (scl_oe_dut) begin
      stretch_left <= stretch;
    end else if (stretch_left != 4'h0) begin
      stretch_left <= stretch_left - 4'h1;
    end
  end
  assign sda_pull = hold_sda;
  assign scl_pull = hold_scl | (stretch_left != 4'h0);
endmodule : scb_bus_partner

//--- scb_i2c_master.sv
`timescale 1ns/1ns
// Operation
// - Start collides if lines low early
// - Start begins released; load counter on high
// - Data low mid-count: reset counter, drive early
// - Count ends: drive data, recount, drive clock
// - Restart collides on data low at clock rise
// - Restart: release, count, release clock, sample
// - Restart data high: recount; late fall ok
// - Restart clock falls early: collision
// - Restart lines high: drive data, count, clock
// - Stop: data low, release clock, count, sample
// - Stop data low after count: collision
// - Stop clock low before data rises: collision
// - Buffer write loads counter; sets buffer full
// - Two reloads per serial clock period
// - Status bit 7 selects SPI sample phase
// - Status bit 7 sets slew control in two-wire
// - Status bit 6 selects edge or thresholds
// - Status bit 5 reports data or address
// - Status bits 4,3 report stop, start; cleared
// - Status bit 2 shows transmit in progress
// - Status bits 1,0: update addr, buffer full
// - Collision sets flag, returns to idle
// - Collision aborts sequence, releases, clears requests
module scb_i2c_master (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic sda_in, // data pin level
  output logic sda_out, // data drive value
  output logic sda_oe, // data pulled low
  input wire logic scl_in, // clock pin level
  output logic scl_out, // clock drive value
  output logic scl_oe, // clock pulled low
  output logic slew_disable, // slew control off
  output logic smbus_levels, // thresholds select
  output logic bus_collision_flag // collision seen
);
  import scb_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] sda_sync, scl_sync;
  logic scl_prev;
  wire sda_s = sda_sync[1];
  wire scl_s = scl_sync[1];
  wire scl_fall = !scl_s && scl_prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_sync <= 2'h3;
      scl_sync <= 2'h3;
      scl_prev <= 1'b1;
    end else begin
      sda_sync <= {sda_sync[0], sda_in};
      scl_sync <= {scl_sync[0], scl_in};
      scl_prev <= scl_s;
    end
  end
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction : is_reg
  wire acc = psel && penable;
  // Writes land at the edge that completes the access, where the master sees pready.
  wire wr = acc && pwrite && pready;
  wire hit_ctrl = is_reg(paddr, SCB_CTRL_OFS);
  wire hit_reload = is_reg(paddr, SCB_RELOAD_OFS);
  wire hit_status = is_reg(paddr, SCB_STATUS_OFS);
  wire hit_buffer = is_reg(paddr, SCB_BUFFER_OFS);
  wire hit_event = is_reg(paddr, SCB_EVENT_OFS);
  wire mapped = hit_ctrl || hit_reload || hit_status || hit_buffer || hit_event;
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_buffer = wr && hit_buffer;
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic port_enable, master_mode;
  logic start_request, restart_request, stop_request, receive_request, ack_request;
  logic [7:0] baud_reload_value;
  logic [7:0] transfer_buffer;
  logic input_sample_phase, edge_select, data_flag, stop_seen, start_seen;
  logic rw_flag, refresh_addr_flag, buffer_full;
  scb_state_type state, next_state;
  logic bc_load, bc_run, bc_expired;
  logic collide;
  logic sda_drive, scl_drive, next_sda_drive, next_scl_drive;
  wire busy = (state != SCB_IDLE);
  wire any_req = start_request || restart_request || stop_request || receive_request || ack_request;
  wire [7:0] status_word = {input_sample_phase, edge_select, data_flag, stop_seen,
                            start_seen, rw_flag, refresh_addr_flag, buffer_full};
  wire [7:0] ctrl_word = {1'b0, master_mode, port_enable, ack_request, receive_request,
                          stop_request, restart_request, start_request};
  wire seq_done = busy && (next_state == SCB_IDLE) && !collide;
  wire req_go = port_enable && master_mode && !busy;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_enable <= 1'b0;
      master_mode <= 1'b0;
      start_request <= 1'b0;
      restart_request <= 1'b0;
      stop_request <= 1'b0;
      receive_request <= 1'b0;
      ack_request <= 1'b0;
      baud_reload_value <= SCB_RELOAD_RESET;
      transfer_buffer <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        port_enable <= pwdata[SCB_CTRL_ENABLE];
        master_mode <= pwdata[SCB_CTRL_MASTER];
      end
      if (collide || seq_done || !port_enable || (!busy && (receive_request || ack_request))) begin
        start_request <= 1'b0;
        restart_request <= 1'b0;
        stop_request <= 1'b0;
        ack_request <= 1'b0;
        receive_request <= 1'b0;
      end else if (wr_ctrl && req_go && !any_req) begin
        start_request <= pwdata[SCB_CTRL_START];
        restart_request <= pwdata[SCB_CTRL_RESTART];
        stop_request <= pwdata[SCB_CTRL_STOP];
        receive_request <= pwdata[SCB_CTRL_RECEIVE];
        ack_request <= pwdata[SCB_CTRL_ACK];
      end
      if (wr && hit_reload) begin
        baud_reload_value <= pwdata[7:0];
      end
      if (wr_buffer && !busy) begin
        transfer_buffer <= pwdata[7:0];
      end
    end
  end
  // ----------------------------------------
  // Status and collision flag
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_sample_phase <= SCB_STATUS_RESET[SCB_ST_PHASE];
      edge_select <= SCB_STATUS_RESET[SCB_ST_EDGE];
      data_flag <= 1'b0;
      stop_seen <= 1'b0;
      start_seen <= 1'b0;
      rw_flag <= 1'b0;
      refresh_addr_flag <= 1'b0;
      buffer_full <= 1'b0;
      bus_collision_flag <= 1'b0;
    end else begin
      if (wr && hit_status) begin
        input_sample_phase <= pwdata[SCB_ST_PHASE];
        edge_select <= pwdata[SCB_ST_EDGE];
      end
      if (!port_enable) begin
        stop_seen <= 1'b0;
        start_seen <= 1'b0;
      end else if (sda_s && scl_s && scl_prev && !sda_sync[1] == 1'b0 && state == SCB_SP_SDAH) begin
        stop_seen <= 1'b1;
        start_seen <= 1'b0;
      end else if ((state == SCB_ST_HOLD || state == SCB_RS_HOLD) && bc_expired) begin
        start_seen <= 1'b1;
        stop_seen <= 1'b0;
      end
      if (wr_buffer && !busy && port_enable) begin
        data_flag <= 1'b1;
        buffer_full <= 1'b1;
        rw_flag <= 1'b1;
      end else if (collide || bc_expired) begin
        buffer_full <= 1'b0;
        rw_flag <= 1'b0;
      end
      refresh_addr_flag <= 1'b0;
      if (collide) begin
        bus_collision_flag <= 1'b1;
      end else if (wr && hit_event && pwdata[0]) begin
        bus_collision_flag <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_sda_drive = sda_drive;
    next_scl_drive = scl_drive;
    bc_load = 1'b0;
    bc_run = busy;
    collide = 1'b0;
    case (state)
      SCB_IDLE: begin
        bc_load = wr_buffer && port_enable && master_mode;
        if (start_request) begin
          if (!sda_s || !scl_s) begin
            collide = 1'b1;
          end else begin
            bc_load = 1'b1;
            next_state = SCB_ST_WAIT;
          end
        end else if (restart_request) begin
          next_sda_drive = 1'b0;
          bc_load = 1'b1;
          next_state = SCB_RS_REL;
        end else if (stop_request) begin
          next_sda_drive = 1'b1;
          next_state = SCB_SP_SCL;
        end
      end
      SCB_ST_WAIT: begin
        if (!scl_s && sda_s) begin
          collide = 1'b1;
        end else if (!sda_s || bc_expired) begin
          next_sda_drive = 1'b1;
          bc_load = 1'b1;
          next_state = SCB_ST_HOLD;
        end
      end
      SCB_ST_HOLD: begin
        if (bc_expired) begin
          next_scl_drive = 1'b1;
          next_state = SCB_IDLE;
        end
      end
      SCB_RS_REL: begin
        if (bc_expired) begin
          next_scl_drive = 1'b0;
          next_state = SCB_RS_SCLH;
        end
      end
      SCB_RS_SCLH: begin
        if (scl_s && !sda_s) begin
          collide = 1'b1;
        end else if (scl_s) begin
          bc_load = 1'b1;
          next_state = SCB_RS_HOLD;
        end
      end
      SCB_RS_HOLD: begin
        if (scl_fall && !sda_drive && sda_s) begin
          collide = 1'b1;
        end else if (bc_expired && !sda_drive) begin
          next_sda_drive = 1'b1;
          bc_load = 1'b1;
        end else if (bc_expired) begin
          next_scl_drive = 1'b1;
          next_state = SCB_IDLE;
        end else if (!sda_s && !sda_drive) begin
          next_sda_drive = 1'b1;
          bc_load = 1'b1;
        end
      end
      SCB_SP_SCL: begin
        if (!sda_s) begin
          next_scl_drive = 1'b0;
        end
        if (!scl_drive && scl_s) begin
          bc_load = 1'b1;
          next_state = SCB_SP_CNT;
        end
      end
      SCB_SP_CNT: begin
        if (!scl_s) begin
          collide = 1'b1;
        end else if (bc_expired) begin
          next_sda_drive = 1'b0;
          bc_load = 1'b1;
          next_state = SCB_SP_SDAH;
        end
      end
      SCB_SP_SDAH: begin
        if (bc_expired && !sda_s) begin
          collide = 1'b1;
        end else if (bc_expired) begin
          next_state = SCB_IDLE;
        end
      end
      default: begin
        next_state = SCB_IDLE;
      end
    endcase
    if (collide || !port_enable) begin
      next_state = SCB_IDLE;
      next_sda_drive = 1'b0;
      next_scl_drive = 1'b0;
      bc_load = 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SCB_IDLE;
      sda_drive <= 1'b0;
      scl_drive <= 1'b0;
    end else begin
      state <= next_state;
      sda_drive <= next_sda_drive;
      scl_drive <= next_scl_drive;
    end
  end
  // Only expiries in SCB_ST_WAIT, SCB_SP_CNT and the first of SCB_RS_HOLD reload; two reloads make one serial clock period.
  scb_baud_counter #(.WIDTH(8)) u_baud_counter (
    .pclk(pclk),
    .presetn(presetn),
    .load(bc_load),
    .run(bc_run),
    .reload_value(baud_reload_value),
    .expired(bc_expired)
  );
  // ----------------------------------------
  // Outputs and APB answer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      slew_disable <= 1'b0;
      smbus_levels <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      sda_oe <= next_sda_drive;
      scl_oe <= next_scl_drive;
      slew_disable <= input_sample_phase;
      smbus_levels <= edge_select;
      pready <= acc && !pready;
      pslverr <= acc && !pready && !mapped;
      prdata <= 32'h0000_0000;
      if (acc && !pready && !pwrite) begin
        if (hit_ctrl) prdata <= {24'h000000, ctrl_word};
        else if (hit_reload) prdata <= {24'h000000, baud_reload_value};
        else if (hit_status) prdata <= {24'h000000, status_word};
        else if (hit_buffer) prdata <= {24'h000000, transfer_buffer};
        else if (hit_event) prdata <= {31'h00000000, bus_collision_flag};
      end
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  early_low_a: assert property ((state == SCB_IDLE && start_request && port_enable && !sda_s) |=>
    bus_collision_flag && state == SCB_IDLE) else $error("start with low line did not collide");
  start_load_a: assert property ((state == SCB_IDLE && start_request && port_enable && sda_s && scl_s) |=>
    state == SCB_ST_WAIT && u_baud_counter.count == baud_reload_value) else $error("start did not load counter");
  early_drive_a: assert property ((state == SCB_ST_WAIT && !sda_s && scl_s && port_enable) |=>
    sda_oe && state == SCB_ST_HOLD) else $error("data not driven early");
  hold_clock_a: assert property ((state == SCB_ST_HOLD && bc_expired && port_enable) |=> scl_oe)
    else $error("clock not driven after start hold");
  rs_case1_a: assert property ((state == SCB_RS_SCLH && scl_s && !sda_s) |=> bus_collision_flag)
    else $error("restart data low not flagged");
  rs_case2_a: assert property ((state == SCB_RS_HOLD && scl_fall && !sda_drive && sda_s) |=>
    bus_collision_flag) else $error("restart clock fall not flagged");
  stop_case2_a: assert property ((state == SCB_SP_CNT && !scl_s) |=>
    bus_collision_flag && !sda_oe && !scl_oe) else $error("stop clock low not flagged");
  abort_release_a: assert property (collide |=> !sda_oe && !scl_oe && !start_request &&
    !stop_request && !restart_request) else $error("collision did not release lines");
endmodule : scb_i2c_master

//--- scb_pkg.sv
package scb_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] SCB_CTRL_OFS = 8'h00;
  localparam logic [7:0] SCB_RELOAD_OFS = 8'h04;
  localparam logic [7:0] SCB_STATUS_OFS = 8'h08;
  localparam logic [7:0] SCB_BUFFER_OFS = 8'h0c;
  localparam logic [7:0] SCB_EVENT_OFS = 8'h10;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int SCB_CTRL_START = 0;
  localparam int SCB_CTRL_RESTART = 1;
  localparam int SCB_CTRL_STOP = 2;
  localparam int SCB_CTRL_RECEIVE = 3;
  localparam int SCB_CTRL_ACK = 4;
  localparam int SCB_CTRL_ENABLE = 5;
  localparam int SCB_CTRL_MASTER = 6;
  // ----------------------------------------
  // Status fields
  // ----------------------------------------
  localparam int SCB_ST_PHASE = 7;
  localparam int SCB_ST_EDGE = 6;
  localparam int SCB_ST_DATA = 5;
  localparam int SCB_ST_STOP = 4;
  localparam int SCB_ST_START = 3;
  localparam int SCB_ST_RW = 2;
  localparam int SCB_ST_UA = 1;
  localparam int SCB_ST_BF = 0;
  localparam logic [7:0] SCB_STATUS_RESET = 8'h00;
  localparam logic [7:0] SCB_RELOAD_RESET = 8'h09;
  localparam logic [1:0] SCB_STATUS_WMASK_HI = 2'h3;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SCB_CLK_MHZ = 100;
  localparam int SCB_RELOADS_PER_PERIOD = 2;
  localparam int SCB_MIN_RELOAD = 3;
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [8:0] {
    SCB_IDLE = 9'h001,
    SCB_ST_WAIT = 9'h002,
    SCB_ST_HOLD = 9'h004,
    SCB_RS_REL = 9'h008,
    SCB_RS_SCLH = 9'h010,
    SCB_RS_HOLD = 9'h020,
    SCB_SP_SCL = 9'h040,
    SCB_SP_CNT = 9'h080,
    SCB_SP_SDAH = 9'h100
  } scb_state_type;
endpackage : scb_pkg

//--- tb_i2c_master_collision_brg.sv
`timescale 1ns/1ns
module tb_i2c_master_collision_brg;
  import scb_pkg::*;
  localparam logic [7:0] RL = 8'h08;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic sda_out, sda_oe, scl_out, scl_oe, slew_disable, smbus_levels, bus_collision_flag;
  logic hold_sda, hold_scl, sda_pull, scl_pull, sda_line, scl_line;
  logic [3:0] stretch;
  int num_errors, tests_run, cycles, start_lat, k;
  // Both lines have pull-ups, so a released line reads high.
  assign sda_line = !(sda_oe | sda_pull);
  assign scl_line = !(scl_oe | scl_pull);
  scb_i2c_master dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sda_in(sda_line),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .scl_in(scl_line),
    .scl_out(scl_out),
    .scl_oe(scl_oe),
    .slew_disable(slew_disable),
    .smbus_levels(smbus_levels),
    .bus_collision_flag(bus_collision_flag)
  );
  scb_bus_partner partner (
    .pclk(pclk),
    .presetn(presetn),
    .scl_oe_dut(scl_oe),
    .hold_sda(hold_sda),
    .hold_scl(hold_scl),
    .stretch(stretch),
    .sda_pull(sda_pull),
    .scl_pull(scl_pull)
  );
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic give_verdict();
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Ends when pready is seen; only the bench timeout at cycle 20000 ends it if pready never comes.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic pick(input int w);
    return (w == 0) ? sda_oe : (w == 1) ? scl_oe : bus_collision_flag;
  endfunction : pick
  // The wait is bounded; a level never reached shows up as a mismatch.
  task automatic wt(input int w, input logic v, output int n);
    n = 0;
    while (pick(w) !== v && n < 300) begin
      @(posedge pclk);
      n++;
    end
    check(32'(pick(w)), 32'(v));
  endtask : wt
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    apb(1'b0, SCB_STATUS_OFS, 32'h0);
    check(rd_q, 32'(SCB_STATUS_RESET));
    apb(1'b0, 8'h14, 32'h0);
    check({rd_q[30:0], rd_e}, 32'h1);
    apb(1'b1, SCB_STATUS_OFS, 32'hff);
    apb(1'b0, SCB_STATUS_OFS, 32'h0);
    check(rd_q, 32'hc0);
    check(32'({slew_disable, smbus_levels}), 32'h3);
    apb(1'b1, SCB_STATUS_OFS, 32'h0);
    apb(1'b1, SCB_CTRL_OFS, 32'h01);
    repeat (30) @(posedge pclk);
    check(32'({sda_out, scl_out, sda_oe, scl_oe, slew_disable, smbus_levels}), 32'h0);
  endtask : t_regs
  task automatic t_start(output int lat);
    int n;
    apb(1'b1, SCB_RELOAD_OFS, 32'(RL));
    // Requests are only taken once the port is already enabled as master.
    apb(1'b1, SCB_CTRL_OFS, 32'h60);
    apb(1'b1, SCB_BUFFER_OFS, 32'h5a);
    apb(1'b0, SCB_STATUS_OFS, 32'h0);
    check(rd_q & 32'h27, 32'h25);
    apb(1'b0, SCB_BUFFER_OFS, 32'h0);
    check(rd_q, 32'h5a);
    apb(1'b1, SCB_CTRL_OFS, 32'h61);
    wt(0, 1'b1, lat);
    check(32'({scl_oe, lat >= RL}), 32'h1);
    wt(1, 1'b1, n);
    check(32'({bus_collision_flag, n >= RL}), 32'h1);
    apb(1'b0, SCB_STATUS_OFS, 32'h0);
    check(rd_q & 32'h18, 32'h08);
    apb(1'b0, SCB_CTRL_OFS, 32'h0);
    check(rd_q & 32'h1f, 32'h0);
  endtask : t_start
  task automatic t_restart();
    int n;
    apb(1'b1, SCB_CTRL_OFS, 32'h62);
    wt(0, 1'b0, n);
    wt(1, 1'b0, n);
    check(32'(n >= RL), 32'h1);
    wt(0, 1'b1, n);
    check(32'({scl_oe, n >= RL}), 32'h1);
    wt(1, 1'b1, n);
    check(32'({bus_collision_flag, n >= RL}), 32'h1);
  endtask : t_restart
  task automatic t_stop(input logic [3:0] s);
    int n;
    stretch <= s;
    apb(1'b1, SCB_CTRL_OFS, 32'h64);
    wt(1, 1'b0, n);
    check(32'(sda_oe), 32'h1);
    wt(0, 1'b0, n);
    check(32'(n >= RL + s), 32'h1);
    repeat (4) @(posedge pclk);
    apb(1'b0, SCB_STATUS_OFS, 32'h0);
    check(rd_q & 32'h18 | 32'(bus_collision_flag), 32'h10);
    stretch <= 4'h0;
  endtask : t_stop
  // Another master pulls data low mid-count: ours follows at once, no collision.
  task automatic t_early();
    int n;
    apb(1'b1, SCB_CTRL_OFS, 32'h61);
    repeat (3) @(posedge pclk);
    hold_sda <= 1'b1;
    wt(0, 1'b1, n);
    check(32'({bus_collision_flag, n + 3 < start_lat}), 32'h1);
    hold_sda <= 1'b0;
    wt(1, 1'b1, n);
  endtask : t_early
  task automatic t_coll(input logic [7:0] c, input logic ps, input logic pc, input logic lc);
    int n;
    if (c != 8'h61) begin
      t_start(n);
    end
    hold_sda <= ps;
    hold_scl <= pc;
    apb(1'b1, SCB_CTRL_OFS, 32'(c));
    if (lc) begin
      wt(1, 1'b0, n);
      repeat (4) @(posedge pclk);
      hold_scl <= 1'b1;
    end
    wt(2, 1'b1, n);
    repeat (2) @(posedge pclk);
    check(32'({sda_oe, scl_oe}), 32'h0);
    apb(1'b0, SCB_CTRL_OFS, 32'h0);
    check(rd_q & 32'h1f, 32'h0);
    hold_sda <= 1'b0;
    hold_scl <= 1'b0;
    apb(1'b1, SCB_EVENT_OFS, 32'h1);
    apb(1'b0, SCB_EVENT_OFS, 32'h0);
    check(rd_q & 32'h1, 32'h0);
  endtask : t_coll
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hold_sda = 1'b0;
    hold_scl = 1'b0;
    stretch = 4'h0;
    num_errors = 0;
    tests_run = 0;
    cycles = 0;
    start_lat = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_start(start_lat);
    t_restart();
    apb(1'b1, SCB_CTRL_OFS, 32'h70);
    apb(1'b0, SCB_CTRL_OFS, 32'h0);
    check(rd_q & 32'h1f, 32'h0);
    t_stop(4'h0);
    t_early();
    t_stop(4'h6);
    t_coll(8'h61, 1'b1, 1'b0, 1'b0);
    t_coll(8'h61, 1'b0, 1'b1, 1'b0);
    t_coll(8'h62, 1'b1, 1'b0, 1'b0);
    t_coll(8'h62, 1'b0, 1'b0, 1'b1);
    t_coll(8'h64, 1'b1, 1'b0, 1'b0);
    t_coll(8'h64, 1'b0, 1'b0, 1'b1);
    t_start(k);
    t_stop(4'h0);
    apb(1'b1, SCB_CTRL_OFS, 32'h0);
    apb(1'b0, SCB_STATUS_OFS, 32'h0);
    check(rd_q & 32'h18, 32'h0);
    give_verdict();
  end
endmodule : tb_i2c_master_collision_brg
